// ---- logic/chan_cfg_consts.svh ----
`ifndef CHAN_CFG_CONSTS_SVH
`define CHAN_CFG_CONSTS_SVH

// Register indices; byte address is four times the index
`define IDX_CH2_GAIN    7'h44
`define IDX_CH2_DELAY   7'h45
`define IDX_CH3_VOLUME  7'h48
`define IDX_CH3_GAIN    7'h49
`define IDX_STATUS      7'h4c

// Reset values
`define RST_GAIN_REG    8'h80
`define RST_DELAY       8'h00
`define RST_VOLUME      8'hc9

// Field positions
`define GAIN_MSB        7
`define GAIN_LSB        4
`define ST_OVERRUN      0
`define ST_MUTED        1

// Codes and scaling
`define VOL_MUTE        8'h00
`define VOL_BIAS        9'h00f
`define VOL_STEPS_OCT   9'h00c
`define VOL_SHIFT_BASE  6'h21
`define TRIM_SHIFT      6'h0f

`endif

// ---- logic/chan_cfg_pkg.sv ----
package chan_cfg_pkg;

	// One decimated sample with its strobe
	typedef struct packed {
		logic              valid;
		logic signed [23:0] data;
	} sample_t;

	// Classic Wishbone request from the master
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  sel;
		logic [8:0]  adr;
		logic [31:0] dat;
	} wb_req_t;

endpackage : chan_cfg_pkg

// ---- logic/tick_delay_queue.sv ----
`timescale 1ns/1ns
// Holds samples and releases each after a set number of modulator ticks
module tick_delay_queue #(
	parameter int DEPTH = 4
) (
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	input  wire logic [7:0]           delay_i,
	input  wire logic                 tick_i,
	input  wire chan_cfg_pkg::sample_t in_i,
	output chan_cfg_pkg::sample_t     out_o,
	output logic                      overrun_o
);
	localparam int PW = $clog2(DEPTH);

	// Pointer arithmetic relies on natural wrap
	if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_chk
		$error("DEPTH must be a power of two, at least 2");
	end

	logic [23:0]   data_reg [DEPTH];   // Held sample per entry
	logic [23:0]   data_next [DEPTH];
	logic [7:0]    cnt_reg [DEPTH];    // Ticks still to wait
	logic [7:0]    cnt_next [DEPTH];
	logic [7:0]    cnt_dec [DEPTH];    // Count after this cycle's tick
	logic [DEPTH-1:0] vld_reg;         // Entry occupied
	logic [DEPTH-1:0] vld_next;
	logic [PW-1:0] wp_reg, wp_next;    // Next free slot
	logic [PW-1:0] rp_reg, rp_next;    // Oldest entry
	chan_cfg_pkg::sample_t out_reg, out_next;
	logic          ovr_reg, ovr_next;

	// Per-entry countdown on each modulator tick
	for (genvar i = 0; i < DEPTH; i++) begin : g_cnt
		assign cnt_dec[i] = (vld_reg[i] && tick_i && cnt_reg[i] != 8'h00)
			? cnt_reg[i] - 8'h01 : cnt_reg[i];
	end

	// Pop the head when its wait is over, push arrivals at the tail
	always_comb begin
		data_next = data_reg;
		cnt_next  = cnt_dec;
		vld_next  = vld_reg;
		wp_next   = wp_reg;
		rp_next   = rp_reg;
		out_next  = '0;
		ovr_next  = 1'b0;
		// Release oldest sample once its delay has elapsed
		if (vld_reg[rp_reg] && cnt_reg[rp_reg] == 8'h00) begin
			out_next.valid   = 1'b1;
			out_next.data    = data_reg[rp_reg];
			vld_next[rp_reg] = 1'b0;
			rp_next          = rp_reg + 1'b1;
		end
		// Accept new sample into the free slot
		if (in_i.valid) begin
			if (!vld_reg[wp_reg]) begin
				data_next[wp_reg] = in_i.data;
				cnt_next[wp_reg]  = delay_i;
				vld_next[wp_reg]  = 1'b1;
				wp_next           = wp_reg + 1'b1;
			end else begin
				// Queue full: sample dropped
				ovr_next = 1'b1;
			end
		end
	end

	// State registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < DEPTH; i++) begin
				data_reg[i] <= 24'h000000;
				cnt_reg[i]  <= 8'h00;
			end
			vld_reg <= '0;
			wp_reg  <= '0;
			rp_reg  <= '0;
			out_reg <= '0;
			ovr_reg <= 1'b0;
		end else begin
			data_reg <= data_next;
			cnt_reg  <= cnt_next;
			vld_reg  <= vld_next;
			wp_reg   <= wp_next;
			rp_reg   <= rp_next;
			out_reg  <= out_next;
			ovr_reg  <= ovr_next;
		end
	end

	assign out_o     = out_reg;
	assign overrun_o = ovr_reg;

endmodule : tick_delay_queue

// ---- logic/chan_cfg_regs.sv ----
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ns
`include "chan_cfg_consts.svh"
// Function
// - Four-bit gain trim, 0.1 dB steps, reset 8
// - Low nibble reserved, reads zero, write zero
// - Delay channel by phase trim modulator cycles
// - Phase trim resets to zero, no delay
// - Volume code zero mutes the channel
// - Volume -100 dB at 1, 0.5 dB steps
// - Volume resets to 201, unity level
// - Only channel 3 has a volume register; channel 2 has none
// - Channel 2 gain register at 0x44, reset 0x80
module chan_cfg_regs #(
	parameter int DELAY_DEPTH = 4
) (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	// Wishbone slave
	input  wire chan_cfg_pkg::wb_req_t wb_i,
	output logic [31:0]                wb_dat_o,
	output logic                       wb_ack_o,
	// Modulator clock tick, one cycle per modulator period
	input  wire logic                  mod_tick_i,
	// Decimated samples in and scaled samples out
	input  wire chan_cfg_pkg::sample_t ch2_sample_i,
	input  wire chan_cfg_pkg::sample_t ch3_sample_i,
	output chan_cfg_pkg::sample_t      ch2_sample_o,
	output chan_cfg_pkg::sample_t      ch3_sample_o
);

	if (DELAY_DEPTH < 2) begin : g_chk
		$error("DELAY_DEPTH must be at least 2");
	end

	// Gain trim code to linear factor, Q1.15, -0.8 dB to +0.7 dB
	function automatic logic [15:0] trim_lin(input logic [3:0] c);
		logic [15:0] f;
		f = 16'h8000;
		unique case (c)
			4'h0: f = 16'h74bd;
			4'h1: f = 16'h7617;
			4'h2: f = 16'h7775;
			4'h3: f = 16'h78d7;
			4'h4: f = 16'h7a3d;
			4'h5: f = 16'h7ba8;
			4'h6: f = 16'h7d16;
			4'h7: f = 16'h7e89;
			4'h8: f = 16'h8000;
			4'h9: f = 16'h817c;
			4'ha: f = 16'h82fb;
			4'hb: f = 16'h8480;
			4'hc: f = 16'h8608;
			4'hd: f = 16'h8796;
			4'he: f = 16'h8928;
			4'hf: f = 16'h8abe;
		endcase
		return f;
	endfunction : trim_lin

	// Half-dB step within one 6 dB octave, Q1.15
	function automatic logic [15:0] vol_mant(input logic [3:0] r);
		logic [15:0] f;
		f = 16'h8000;
		unique case (r)
			4'h0: f = 16'h8000;
			4'h1: f = 16'h8796;
			4'h2: f = 16'h8f9e;
			4'h3: f = 16'h9821;
			4'h4: f = 16'ha124;
			4'h5: f = 16'haab1;
			4'h6: f = 16'hb4ce;
			4'h7: f = 16'hbf85;
			4'h8: f = 16'hcade;
			4'h9: f = 16'hd6e3;
			4'ha: f = 16'he39f;
			4'hb: f = 16'hf11c;
			default: f = 16'h8000;
		endcase
		return f;
	endfunction : vol_mant

	// Multiply, shift right and clamp to the 24-bit sample range
	function automatic logic signed [23:0] scale(
		input logic signed [23:0] s,
		input logic [15:0]        m,
		input logic [5:0]         sh
	);
		logic signed [40:0] p;
		p = s * $signed({1'b0, m});
		p = p >>> sh;
		if (p > 41'sh000007fffff) begin
			return 24'h7fffff;
		end else if (p < -41'sh000000800000) begin
			return 24'h800000;
		end
		return p[23:0];
	endfunction : scale

	// Register file state
	logic [3:0] ch2_gain_reg, ch2_gain_next;     // Channel 2 trim nibble
	logic [7:0] ch2_delay_reg, ch2_delay_next;   // Channel 2 phase trim
	logic [7:0] ch3_vol_reg, ch3_vol_next;       // Channel 3 volume code
	logic [3:0] ch3_gain_reg, ch3_gain_next;     // Channel 3 trim nibble
	logic       ovr_reg, ovr_next;               // Sticky delay overrun
	logic       ack_reg, ack_next;               // Bus acknowledge
	logic [31:0] rdat_reg, rdat_next;            // Read data
	logic [6:0] idx;                             // Word index of access
	logic       wr_commit;                       // Write lands this edge
	logic [7:0] rd_byte;                         // Selected register value
	logic       q_overrun;                       // Drop pulse from queue

	assign idx       = wb_i.adr[8:2];
	assign wr_commit = wb_i.cyc && wb_i.stb && wb_i.we && ack_reg && wb_i.sel[0];

	// Read mux; unmapped words read zero
	always_comb begin
		rd_byte = 8'h00;
		unique case (idx)
			`IDX_CH2_GAIN:   rd_byte = {ch2_gain_reg, 4'h0};
			`IDX_CH2_DELAY:  rd_byte = ch2_delay_reg;
			`IDX_CH3_VOLUME: rd_byte = ch3_vol_reg;
			`IDX_CH3_GAIN:   rd_byte = {ch3_gain_reg, 4'h0};
			`IDX_STATUS:     rd_byte = {6'h00, ch3_vol_reg == `VOL_MUTE, ovr_reg};
			default:         rd_byte = 8'h00;
		endcase
	end

	// Bus handshake and register writes
	always_comb begin
		ch2_gain_next  = ch2_gain_reg;
		ch2_delay_next = ch2_delay_reg;
		ch3_vol_next   = ch3_vol_reg;
		ch3_gain_next  = ch3_gain_reg;
		ovr_next       = ovr_reg;
		// Ack one cycle after the request, drop it the cycle after
		ack_next  = wb_i.cyc && wb_i.stb && !ack_reg;
		rdat_next = ack_next ? {24'h000000, rd_byte} : 32'h00000000;
		// Writes take effect at the edge where ack is seen
		if (wr_commit) begin
			unique case (idx)
				`IDX_CH2_GAIN: begin
					// Reserved low nibble is not stored
					ch2_gain_next = wb_i.dat[`GAIN_MSB:`GAIN_LSB];
				end
				`IDX_CH2_DELAY:  ch2_delay_next = wb_i.dat[7:0];
				`IDX_CH3_VOLUME: ch3_vol_next   = wb_i.dat[7:0];
				`IDX_CH3_GAIN:   ch3_gain_next  = wb_i.dat[`GAIN_MSB:`GAIN_LSB];
				`IDX_STATUS: begin
					// Write one clears the overrun flag
					if (wb_i.dat[`ST_OVERRUN]) begin
						ovr_next = 1'b0;
					end
				end
				default: begin
					// Unmapped write ignored
				end
			endcase
		end
		// A new overrun wins over a clear in the same cycle
		if (q_overrun) begin
			ovr_next = 1'b1;
		end
	end

	// Register file flip-flops
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ch2_gain_reg  <= 4'(`RST_GAIN_REG >> 4);
			ch2_delay_reg <= `RST_DELAY;
			ch3_vol_reg   <= `RST_VOLUME;
			ch3_gain_reg  <= 4'(`RST_GAIN_REG >> 4);
			ovr_reg       <= 1'b0;
			ack_reg       <= 1'b0;
			rdat_reg      <= 32'h00000000;
		end else begin
			ch2_gain_reg  <= ch2_gain_next;
			ch2_delay_reg <= ch2_delay_next;
			ch3_vol_reg   <= ch3_vol_next;
			ch3_gain_reg  <= ch3_gain_next;
			ovr_reg       <= ovr_next;
			ack_reg       <= ack_next;
			rdat_reg      <= rdat_next;
		end
	end

	assign wb_dat_o = rdat_reg;
	assign wb_ack_o = ack_reg;

	// Channel 2 phase delay ahead of the gain stage
	chan_cfg_pkg::sample_t ch2_dly;  // Delayed channel 2 sample

	tick_delay_queue #(
		.DEPTH(DELAY_DEPTH)
	) u_ch2_delay (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.delay_i  (ch2_delay_reg),
		.tick_i   (mod_tick_i),
		.in_i     (ch2_sample_i),
		.out_o    (ch2_dly),
		.overrun_o(q_overrun)
	);

	// Volume code split into octave shift and half-dB mantissa
	logic [8:0]  vol_biased;  // Code plus bias, unity at a whole octave
	logic [8:0]  vol_oct;     // Whole 6 dB octaves
	logic [8:0]  vol_rem;     // Half-dB steps left over
	logic [5:0]  vol_shift;   // Right shift applied after the product
	logic [15:0] vol_factor;  // Mantissa for the remainder

	// Level rises 0.5 dB per code from -100 dB at code 1
	always_comb begin
		vol_biased = {1'b0, ch3_vol_reg} + `VOL_BIAS;
		vol_oct    = vol_biased / `VOL_STEPS_OCT;
		vol_rem    = vol_biased % `VOL_STEPS_OCT;
		vol_shift  = `VOL_SHIFT_BASE - vol_oct[5:0];
		vol_factor = vol_mant(vol_rem[3:0]);
	end

	// Sample pipeline state
	chan_cfg_pkg::sample_t ch2_out_reg, ch2_out_next;   // Channel 2 result
	chan_cfg_pkg::sample_t ch3_trim_reg, ch3_trim_next; // Channel 3 after trim
	chan_cfg_pkg::sample_t ch3_out_reg, ch3_out_next;   // Channel 3 result

	// Gain trim and volume on decimated samples before output
	always_comb begin
		ch2_out_next  = '0;
		ch3_trim_next = '0;
		ch3_out_next  = '0;
		// Channel 2: trim after the delay queue
		if (ch2_dly.valid) begin
			ch2_out_next.valid = 1'b1;
			ch2_out_next.data  = scale(ch2_dly.data, trim_lin(ch2_gain_reg),
				`TRIM_SHIFT);
		end
		// Channel 3: trim stage
		if (ch3_sample_i.valid) begin
			ch3_trim_next.valid = 1'b1;
			ch3_trim_next.data  = scale(ch3_sample_i.data, trim_lin(ch3_gain_reg),
				`TRIM_SHIFT);
		end
		// Channel 3: volume stage, zero code mutes
		if (ch3_trim_reg.valid) begin
			ch3_out_next.valid = 1'b1;
			if (ch3_vol_reg == `VOL_MUTE) begin
				ch3_out_next.data = 24'h000000;
			end else begin
				ch3_out_next.data = scale(ch3_trim_reg.data, vol_factor,
					vol_shift);
			end
		end
	end

	// Sample pipeline flip-flops
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ch2_out_reg  <= '0;
			ch3_trim_reg <= '0;
			ch3_out_reg  <= '0;
		end else begin
			ch2_out_reg  <= ch2_out_next;
			ch3_trim_reg <= ch3_trim_next;
			ch3_out_reg  <= ch3_out_next;
		end
	end

	assign ch2_sample_o = ch2_out_reg;
	assign ch3_sample_o = ch3_out_reg;

endmodule : chan_cfg_regs

// ---- tb/chan_cfg_regs_asserts.sv ----
`timescale 1ns/1ns
// Watches the register bus and both sample paths
module chan_cfg_regs_asserts (
	input wire logic                  clk_i,
	input wire logic                  rst_i,
	input wire chan_cfg_pkg::wb_req_t wb_i,
	input wire logic [31:0]           wb_dat_o,
	input wire logic                  wb_ack_o,
	input wire logic                  mod_tick_i,
	input wire chan_cfg_pkg::sample_t ch2_sample_i,
	input wire chan_cfg_pkg::sample_t ch3_sample_i,
	input wire chan_cfg_pkg::sample_t ch2_sample_o,
	input wire chan_cfg_pkg::sample_t ch3_sample_o
);
	logic       req;      // Request on the bus
	logic       rd;       // Read in its ack cycle
	logic [7:0] vol_reg;  // Shadow of channel 3 volume
	logic [7:0] vol_next; // Its next value
	assign req = wb_i.cyc & wb_i.stb;
	assign rd = wb_ack_o & req & ~wb_i.we;
	// Shadow takes writes at the ack edge
	always_comb begin
		vol_next = vol_reg;
		if (wb_ack_o && req && wb_i.we && wb_i.sel[0] && wb_i.adr[8:2] == 7'h48) begin
			vol_next = wb_i.dat[7:0];
		end
	end
	// Register the shadow
	always_ff @(posedge clk_i) begin
		vol_reg <= rst_i ? 8'hc9 : vol_next;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	ack_after_req_a: assert property (req && !wb_ack_o |=> wb_ack_o)
		else $error("no ack");
	ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	ack_cause_a: assert property (wb_ack_o |-> $past(req) && !$past(wb_ack_o))
		else $error("ack without request");
	idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data off ack");
	resv_zero_a: assert property (rd && (wb_i.adr[8:2] == 7'h44 || wb_i.adr[8:2] == 7'h49)
		|-> wb_dat_o[3:0] == 4'h0 && wb_dat_o[31:8] == 24'h0)
		else $error("reserved bits nonzero");
	vol_read_a: assert property (rd && wb_i.adr[8:2] == 7'h48 |-> wb_dat_o == {24'h0, vol_reg})
		else $error("volume readback");
	ch3_latency_a: assert property (ch3_sample_i.valid |-> ##2 ch3_sample_o.valid)
		else $error("ch3 late");
	ch3_cause_a: assert property (ch3_sample_o.valid |-> $past(ch3_sample_i.valid, 2))
		else $error("ch3 spurious");
	mute_zero_a: assert property (ch3_sample_o.valid && vol_reg == 8'h00
		|-> ch3_sample_o.data == 24'h0)
		else $error("mute leaks");
	ch2_quiet_a: assert property (!ch2_sample_o.valid |-> ch2_sample_o.data == 24'h0)
		else $error("ch2 data off valid");
endmodule : chan_cfg_regs_asserts

// ---- tb/chan_cfg_regs_test.sv ----
`timescale 1ns/1ns
// Self-checking bench for the channel trim registers
module chan_cfg_regs_test;
	logic                  clk_i = 1'b0;
	logic                  rst_i = 1'b1;
	chan_cfg_pkg::wb_req_t wb_i = '0;
	logic [31:0]           wb_dat_o;
	logic                  wb_ack_o;
	logic                  mod_tick_i = 1'b0;
	chan_cfg_pkg::sample_t ch2_sample_i = '0;
	chan_cfg_pkg::sample_t ch3_sample_i = '0;
	chan_cfg_pkg::sample_t ch2_sample_o;
	chan_cfg_pkg::sample_t ch3_sample_o;
	int                    num_errors = 0;
	int                    total_checks = 0;
	int                    cycles = 0;
	logic [31:0]           rd;       // Last read data
	logic [7:0]            d;        // Scratch byte
	logic signed [23:0]    s;        // Scratch sample
	logic [6:0]            ix [4] = '{7'h44, 7'h45, 7'h48, 7'h49};
	logic [7:0]            rv [4] = '{8'h80, 8'h00, 8'hc9, 8'h80};
	logic [7:0]            vl [4] = '{8'h00, 8'hbd, 8'hc9, 8'hd5};
	logic [7:0]            dl [3] = '{8'h00, 8'h01, 8'hff};
	always #20 clk_i = ~clk_i;
	chan_cfg_regs #(.DELAY_DEPTH(4)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mod_tick_i(mod_tick_i),
		.ch2_sample_i(ch2_sample_i), .ch3_sample_i(ch3_sample_i),
		.ch2_sample_o(ch2_sample_o), .ch3_sample_o(ch3_sample_o));
	// Compare and count
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s exp %h seen %h", what, exp, seen);
		end
	endtask : check
	// Counts, verdict, end of run
	task print_verdict;
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : print_verdict
	// One classic bus cycle, held until ack
	task bus(input logic we, input logic [6:0] a, input logic [7:0] v);
		wb_i <= '{1'b1, 1'b1, we, 4'h1, {a, 2'b00}, {24'h0, v}};
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1) @(posedge clk_i);
		rd = wb_dat_o;
		wb_i <= '0;
		@(posedge clk_i);
	endtask : bus
	// Expected channel 3 level; octave steps are exact
	function logic signed [23:0] vexp(input logic [7:0] v, input logic signed [23:0] x);
		case (v)
			8'h00: vexp = 24'sh0;
			8'hbd: vexp = x >>> 1;
			8'hd5: vexp = x <<< 1;
			default: vexp = x;
		endcase
	endfunction : vexp
	// Channel 2: count ticks seen before output
	task ch2(input logic [7:0] dv);
		int i;
		int t;
		bus(1'b1, 7'h45, dv);
		ch2_sample_i <= '{1'b1, s};
		@(posedge clk_i);
		ch2_sample_i <= '0;
		i = 0;
		t = 0;
		while (ch2_sample_o.valid !== 1'b1 && i < 1500) begin
			mod_tick_i <= (i % 5 == 4);
			@(posedge clk_i);
			t += mod_tick_i;
			i++;
		end
		mod_tick_i <= 1'b0;
		check("ch2 ticks", t, {24'h0, dv});
		check("ch2 data", ch2_sample_o.data, s);
	endtask : ch2
	// Hang guard
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			print_verdict();
		end
	end
	// Main sequence
	initial begin
		void'($urandom(32'hea560d0a));
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		for (int k = 0; k < 4; k++) begin
			bus(1'b0, ix[k], 8'h00);
			check("reset value", rd, {24'h0, rv[k]});
		end
		$display("reset values done");
		for (int k = 0; k < 16; k++) begin
			d = {k[3:0], 4'h0};
			bus(1'b1, 7'h44, d);
			bus(1'b1, 7'h49, {~d[7:4], 4'h0});
			bus(1'b0, 7'h44, 8'h00);
			check("gain2", rd, {24'h0, d[7:4], 4'h0});
			bus(1'b0, 7'h49, 8'h00);
			check("gain3", rd, {24'h0, ~d[7:4], 4'h0});
		end
		$display("gain codes done");
		d = 8'($urandom);
		bus(1'b1, 7'h48, d);
		bus(1'b1, 7'h46, 8'h5a);
		bus(1'b0, 7'h46, 8'h00);
		check("unmapped", rd, 32'h0);
		bus(1'b0, 7'h48, 8'h00);
		check("volume", rd, {24'h0, d});
		bus(1'b0, 7'h4c, 8'h00);
		check("mute flag", rd, {30'h0, d == 8'h00, 1'b0});
		bus(1'b0, 7'h45, 8'h00);
		check("delay kept", rd, 32'h0);
		$display("volume register done");
		bus(1'b1, 7'h49, 8'h80);
		bus(1'b1, 7'h44, 8'h80);
		for (int k = 0; k < 4; k++) begin
			s = 24'($signed(20'($urandom)));
			bus(1'b1, 7'h48, vl[k]);
			ch3_sample_i <= '{1'b1, s};
			@(posedge clk_i);
			ch3_sample_i <= '0;
			repeat (2) @(posedge clk_i);
			check("ch3 valid", ch3_sample_o.valid, 32'h1);
			check("ch3 data", ch3_sample_o.data, vexp(vl[k], s));
		end
		$display("volume path done");
		for (int k = 0; k < 3; k++) begin
			s = 24'($signed(20'($urandom)));
			ch2(dl[k]);
		end
		$display("delay path done");
		print_verdict();
	end
endmodule : chan_cfg_regs_test
bind chan_cfg_regs chan_cfg_regs_asserts chk (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mod_tick_i(mod_tick_i),
	.ch2_sample_i(ch2_sample_i), .ch3_sample_i(ch3_sample_i),
	.ch2_sample_o(ch2_sample_o), .ch3_sample_o(ch3_sample_o));
